// ==== hw/conv_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module conv_regs #(
  parameter logic [1:0] PART_ID = 2'h1, // arbitrary value
  parameter logic [2:0] DIE_ID  = 3'h0  // arbitrary value
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        wr_stb,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_stb,
  input  wire logic [15:0] conv_word,
  input  wire logic        sample_valid_flag,
  input  wire logic        stage1_valid,
  input  wire logic [15:0] stage1_mag,
  input  wire logic        mod_tick,
  input  wire logic        mod_over_full,
  input  wire logic        run_sum_valid,
  input  wire logic [15:0] run_sum,
  output logic      [15:0] rd_data,
  output logic             internal_clock_en,
  output logic             sync_pulse,
  output logic             coeff_we,
  output logic      [31:0] coeff_word,
  output logic       [5:0] coeff_index,
  output logic             third_stage_active,
  output logic             first_stage_active,
  output logic       [2:0] rate_reduce_field,
  output logic             chip_sleep,
  output logic             economy_mode,
  output logic             amp_sleep,
  output logic             user_filter,
  output logic      [15:0] gain_q,
  output logic      [15:0] offset_q
);
  // identity values must fill their status fields exactly
  if ($bits(PART_ID) != 2) begin : g_bad_part
    $error("part ident must be two bits");
  end
  if ($bits(DIE_ID) != 3) begin : g_bad_die
    $error("die ident must be three bits");
  end

  // sequencer, readback and stored registers
  conv_regs_pkg::wstate_type   ws_q;
  conv_regs_pkg::wstate_type   ws_d;
  conv_regs_pkg::readback_type rb_q;
  logic [15:0]                 addr_q;
  logic [15:0]                 primary_q;
  logic [15:0]                 secondary_q;
  logic [15:0]                 thresh_q;
  // download state and checksums
  logic [15:0]                 sum_q;
  logic [15:0]                 load_sum_q;
  logic [15:0]                 hi_word_q;
  logic                        half_q;
  logic  [5:0]                 coef_total_q;
  // status flags and rate helpers
  logic                        load_ok_q;
  logic                        run_ok_q;
  logic                        over_q;
  logic  [2:0]                 run_cnt_q;
  logic                        div_q;

  // decode of the data-word write by address
  wire data_wr    = wr_stb && (ws_q == conv_regs_pkg::WS_DATA);
  wire wr_primary = data_wr && (addr_q == conv_regs_pkg::ADDR_PRIMARY);
  wire wr_second  = data_wr && (addr_q == conv_regs_pkg::ADDR_SECONDARY);
  wire wr_offset  = data_wr && (addr_q == conv_regs_pkg::ADDR_OFFSET);
  wire wr_gain    = data_wr && (addr_q == conv_regs_pkg::ADDR_GAIN);
  wire wr_thresh  = data_wr && (addr_q == conv_regs_pkg::ADDR_THRESHOLD);
  wire start_load = wr_primary && wr_data[conv_regs_pkg::LOAD_BIT];
  // words taken outside the register data write
  wire addr_wr    = wr_stb && (ws_q == conv_regs_pkg::WS_ADDR);
  wire coef_wr    = wr_stb && (ws_q == conv_regs_pkg::WS_COEF);
  wire sum_wr     = wr_stb && (ws_q == conv_regs_pkg::WS_SUM);
  wire lo_wr      = coef_wr && half_q;
  // tap count field: odd codes give 6*(n+1)/2 coefficients, zero is default
  wire [3:0] taps_f   = wr_data[conv_regs_pkg::TAPS_LSB +: 4];
  wire [5:0] n_coef   = 6'(({2'h0, taps_f} + 6'h01) >> 1) * 6'h06;
  wire [5:0] next_idx = coeff_index + 6'h01;
  wire       last_coef = half_q && (next_idx == coef_total_q);
  // checksum adds the four bytes of each padded coefficient
  wire [31:0] full_word = {hi_word_q, wr_data};
  wire [15:0] byte_sum  = 16'(full_word[31:24]) + 16'(full_word[23:16])
                        + 16'(full_word[15:8]) + 16'(full_word[7:0]);

  // status fields taken from the control registers
  wire       stage3_off = ~primary_q[conv_regs_pkg::STAGE3_BIT];
  wire       stage1_off = ~primary_q[conv_regs_pkg::STAGE1_BIT];
  wire [2:0] rate_echo  = primary_q[2:0];
  wire       econ_on    = secondary_q[conv_regs_pkg::ECON_BIT];

  // status word
  wire [15:0] status_w = {PART_ID, DIE_ID, sample_valid_flag,
                          econ_on, over_q,
                          load_ok_q, run_ok_q, user_filter,
                          stage3_off, stage1_off, rate_echo};

  // readback selection from the select bits of a primary write
  wire [4:0] sel_bits = wr_data[15:11];
  conv_regs_pkg::readback_type rb_next;
  always_comb begin
    rb_next = rb_q;
    if (wr_primary) begin
      if (sel_bits[3])      rb_next = conv_regs_pkg::RB_OVR;
      else if (sel_bits[2]) rb_next = conv_regs_pkg::RB_GAIN;
      else if (sel_bits[1]) rb_next = conv_regs_pkg::RB_OFF;
      else if (sel_bits[0]) rb_next = conv_regs_pkg::RB_STAT;
    end else if (rd_stb) begin
      rb_next = conv_regs_pkg::RB_DATA;
    end
  end

  wire [15:0] rd_mux = (rb_q == conv_regs_pkg::RB_OVR)  ? thresh_q :
                       (rb_q == conv_regs_pkg::RB_GAIN) ? gain_q :
                       (rb_q == conv_regs_pkg::RB_OFF)  ? offset_q :
                       (rb_q == conv_regs_pkg::RB_STAT) ? status_w : conv_word;

  // write sequencer: address, data, then optional coefficient stream
  always_comb begin
    ws_d = ws_q;
    case (ws_q)
      conv_regs_pkg::WS_ADDR: if (wr_stb) ws_d = conv_regs_pkg::WS_DATA;
      conv_regs_pkg::WS_DATA: begin
        if (wr_stb) ws_d = (start_load && n_coef != 6'h00) ?
                            conv_regs_pkg::WS_COEF : conv_regs_pkg::WS_ADDR;
      end
      conv_regs_pkg::WS_COEF: if (coef_wr && last_coef) ws_d = conv_regs_pkg::WS_SUM;
      conv_regs_pkg::WS_SUM:  if (wr_stb) ws_d = conv_regs_pkg::WS_ADDR;
      default:                ws_d = conv_regs_pkg::WS_ADDR;
    endcase
  end

  // sequencer and address capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ws_q   <= conv_regs_pkg::WS_ADDR;
      addr_q <= 16'h0000;
      rb_q   <= conv_regs_pkg::RB_DATA;
    end else begin
      ws_q <= ws_d;
      rb_q <= rb_next;
      if (addr_wr) addr_q <= wr_data;
    end
  end

  // control and correction registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      primary_q   <= conv_regs_pkg::PRIMARY_RST;
      secondary_q <= conv_regs_pkg::SECONDARY_RST;
      offset_q    <= conv_regs_pkg::OFFSET_RST;
      gain_q      <= conv_regs_pkg::GAIN_RST;
      thresh_q    <= conv_regs_pkg::THRESHOLD_RST;
    end else begin
      if (wr_primary) primary_q <= wr_data & ~conv_regs_pkg::SELF_CLEAR_MASK
                                           & ~conv_regs_pkg::RESERVED1_MASK;
      if (wr_second)  secondary_q <= (wr_data & conv_regs_pkg::SECONDARY_MASK)
                                     | 16'h0002;
      if (wr_offset)  offset_q <= wr_data;
      if (wr_gain)    gain_q   <= wr_data;
      if (wr_thresh)  thresh_q <= wr_data;
    end
  end

  // coefficient download and checksum
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      half_q       <= 1'b0;
      hi_word_q    <= 16'h0000;
      coeff_index  <= 6'h00;
      coef_total_q <= 6'h00;
      sum_q        <= 16'h0000;
      load_sum_q   <= 16'h0000;
      load_ok_q    <= 1'b0;
      user_filter  <= 1'b0;
    end else begin
      if (start_load) begin
        half_q       <= 1'b0;
        coeff_index  <= 6'h00;
        coef_total_q <= n_coef;
        sum_q        <= 16'h0000;
        load_ok_q    <= 1'b0;
        user_filter  <= (n_coef != 6'h00);
      end else if (coef_wr) begin
        half_q <= ~half_q;
        if (!half_q) begin
          hi_word_q <= wr_data;
        end else begin
          sum_q       <= sum_q + byte_sum;
          if (!last_coef) coeff_index <= next_idx;
        end
      end else if (sum_wr) begin
        load_sum_q <= wr_data;
        load_ok_q  <= (wr_data == sum_q);
      end
    end
  end

  // coefficient strobe towards the filter memory, one per padded word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      coeff_we   <= 1'b0;
      coeff_word <= 32'h0000_0000;
    end else begin
      coeff_we <= lo_wr;
      if (lo_wr) coeff_word <= full_word;
    end
  end

  // over-full run counter: consecutive over samples, held at the limit
  wire       run_at_limit = (run_cnt_q == 3'(conv_regs_pkg::OVER_RUN));
  wire [2:0] run_cnt_d    = !mod_over_full ? 3'h0 : (run_at_limit ? run_cnt_q : run_cnt_q + 3'h1);
  wire       over_run_hit = mod_tick && mod_over_full && run_at_limit;

  // running checksum compare; a new result wins over the download restart
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_ok_q <= 1'b0;
    end else if (run_sum_valid) begin
      run_ok_q <= user_filter && (run_sum == load_sum_q);
    end else if (start_load) begin
      run_ok_q <= 1'b0;
    end
  end

  // overrange flag: a long over-full run wins over the threshold compare
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      over_q    <= 1'b0;
      run_cnt_q <= 3'h0;
    end else begin
      if (mod_tick) run_cnt_q <= run_cnt_d;
      if (over_run_hit)      over_q <= 1'b1;
      else if (stage1_valid) over_q <= (stage1_mag > thresh_q);
    end
  end

  // internal clock enable from the halve select
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q             <= 1'b0;
      internal_clock_en <= 1'b0;
    end else begin
      div_q             <= ~div_q;
      internal_clock_en <= secondary_q[conv_regs_pkg::HALVE_BIT] | div_q;
    end
  end

  // readback word, held until the next read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else if (rd_stb) begin
      rd_data <= rd_mux;
    end
  end

  // registered control outputs, reset to what the register resets hold
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_pulse         <= 1'b0;
      third_stage_active <= conv_regs_pkg::PRIMARY_RST[conv_regs_pkg::STAGE3_BIT];
      first_stage_active <= conv_regs_pkg::PRIMARY_RST[conv_regs_pkg::STAGE1_BIT];
      rate_reduce_field  <= conv_regs_pkg::PRIMARY_RST[2:0];
      chip_sleep         <= conv_regs_pkg::SECONDARY_RST[conv_regs_pkg::SLEEP_BIT];
      economy_mode       <= conv_regs_pkg::SECONDARY_RST[conv_regs_pkg::ECON_BIT];
      amp_sleep          <= conv_regs_pkg::SECONDARY_RST[conv_regs_pkg::AMPSLP_BIT];
    end else begin
      sync_pulse         <= wr_primary && wr_data[conv_regs_pkg::SYNC_BIT];
      third_stage_active <= primary_q[conv_regs_pkg::STAGE3_BIT];
      first_stage_active <= primary_q[conv_regs_pkg::STAGE1_BIT];
      rate_reduce_field  <= primary_q[2:0];
      chip_sleep         <= secondary_q[conv_regs_pkg::SLEEP_BIT];
      economy_mode       <= secondary_q[conv_regs_pkg::ECON_BIT];
      amp_sleep          <= secondary_q[conv_regs_pkg::AMPSLP_BIT];
    end
  end
endmodule : conv_regs
`default_nettype wire

// ==== inc/conv_regs_pkg.sv ====
`default_nettype none
package conv_regs_pkg;
  // register addresses (word written before the data word)
  localparam logic [15:0] ADDR_PRIMARY   = 16'h0001;
  localparam logic [15:0] ADDR_SECONDARY = 16'h0002;
  localparam logic [15:0] ADDR_OFFSET    = 16'h0003;
  localparam logic [15:0] ADDR_GAIN      = 16'h0004;
  localparam logic [15:0] ADDR_THRESHOLD = 16'h0005;
  // reset values
  localparam logic [15:0] PRIMARY_RST    = 16'h001A;
  localparam logic [15:0] SECONDARY_RST  = 16'h009B;
  localparam logic [15:0] OFFSET_RST     = 16'h0000;
  localparam logic [15:0] GAIN_RST       = 16'hA000;
  localparam logic [15:0] THRESHOLD_RST  = 16'hCCCC;
  // primary control fields
  localparam int LOAD_BIT   = 15;
  localparam int RD_OVR_BIT = 14;
  localparam int RD_GAIN_BIT = 13;
  localparam int RD_OFF_BIT = 12;
  localparam int RD_STAT_BIT = 11;
  localparam int SYNC_BIT   = 9;
  localparam int TAPS_LSB   = 5;
  localparam int STAGE3_BIT = 4;
  localparam int STAGE1_BIT = 3;
  localparam logic [15:0] SELF_CLEAR_MASK = 16'hFE00;
  localparam logic [15:0] RESERVED1_MASK  = 16'h0400;
  // secondary control fields
  localparam int HALVE_BIT   = 5;
  localparam int SLEEP_BIT   = 3;
  localparam int ECON_BIT    = 2;
  localparam int MUST1_BIT   = 1;
  localparam int AMPSLP_BIT  = 0;
  localparam logic [15:0] SECONDARY_MASK = 16'h002F;
  // overrange run length at modulator rate
  localparam int OVER_RUN = 4;
  // readback selection and write sequencer states
  typedef enum logic [4:0] {
    RB_DATA = 5'h01,
    RB_OVR  = 5'h02,
    RB_GAIN = 5'h04,
    RB_OFF  = 5'h08,
    RB_STAT = 5'h10
  } readback_type;
  typedef enum logic [3:0] {
    WS_ADDR = 4'h1,
    WS_DATA = 4'h2,
    WS_COEF = 4'h4,
    WS_SUM  = 4'h8
  } wstate_type;
endpackage : conv_regs_pkg
`default_nettype wire

// ==== verif/conv_regs_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module conv_regs_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic        internal_clock_en,
  input wire logic        sync_pulse,
  input wire logic        coeff_we,
  input wire logic        third_stage_active,
  input wire logic        first_stage_active,
  input wire logic [2:0]  rate_reduce_field,
  input wire logic        chip_sleep,
  input wire logic        economy_mode,
  input wire logic        amp_sleep,
  input wire logic        user_filter,
  input wire logic [15:0] gain_q,
  input wire logic [15:0] offset_q
);
  // one clock domain, reset disables every check
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // pulses, holds and reset values
  sync_single_a: assert property (sync_pulse |=> !sync_pulse) else $error("sync pulse too long");
  sync_cause_a: assert property (sync_pulse |-> $past(wr_stb) || $past(wr_stb, 2))
    else $error("sync pulse without write");
  load_cause_a: assert property (coeff_we |-> $past(wr_stb) || $past(wr_stb, 2))
    else $error("coefficient without write");
  corr_reset_a: assert property ($fell(rst) |-> gain_q == 16'hA000 && offset_q == 16'h0000)
    else $error("correction reset value");
  stage_reset_a: assert property ($fell(rst) |-> third_stage_active && first_stage_active && rate_reduce_field == 3'h2)
    else $error("filter reset setting");
  power_reset_a: assert property ($fell(rst) |-> amp_sleep && chip_sleep && !economy_mode && !user_filter)
    else $error("power reset setting");
  clk_gap_a: assert property (!internal_clock_en && !$past(rst) |=> internal_clock_en)
    else $error("clock enable gap");
  read_hold_a: assert property (!rd_stb |=> $stable(rd_data)) else $error("read data moved");
  econ_cause_a: assert property ($changed(economy_mode) |-> $past(wr_stb) || $past(wr_stb, 2))
    else $error("economy change without write");
  // main scenarios
  cover property (coeff_we);
  cover property (sync_pulse);
  cover property (rd_stb ##1 rd_data == 16'hCCCC);
endmodule : conv_regs_checker
bind conv_regs conv_regs_checker chk (.clk_sys(clk_sys), .rst(rst), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rd_data(rd_data), .internal_clock_en(internal_clock_en), .sync_pulse(sync_pulse), .coeff_we(coeff_we),
  .third_stage_active(third_stage_active), .first_stage_active(first_stage_active),
  .rate_reduce_field(rate_reduce_field), .chip_sleep(chip_sleep), .economy_mode(economy_mode),
  .amp_sleep(amp_sleep), .user_filter(user_filter), .gain_q(gain_q), .offset_q(offset_q));
`default_nettype wire

// ==== verif/bus_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module bus_host (
  input  wire logic        clk_sys,
  input  wire logic [15:0] rd_data,
  output var  logic        wr_stb,
  output var  logic [15:0] wr_data,
  output var  logic        rd_stb
);
  // idle bus at time zero
  initial begin
    wr_stb = 1'b0;
    wr_data = 16'h0000;
    rd_stb = 1'b0;
  end
  // one word, then a released cycle
  task automatic wd(input logic [15:0] d);
    wr_stb = 1'b1;
    wr_data = d;
    @(posedge clk_sys);
    #1;
    wr_stb = 1'b0;
    wr_data = ~d; // no stale value on a released bus
    @(posedge clk_sys);
    #1;
  endtask : wd
  // address word then data word
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    wd(a);
    wd(d);
  endtask : wr
  // read strobe, data one cycle later
  task automatic rd(output logic [15:0] v);
    rd_stb = 1'b1;
    @(posedge clk_sys);
    #1;
    rd_stb = 1'b0;
    @(posedge clk_sys);
    #1;
    v = rd_data;
  endtask : rd
endmodule : bus_host
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        wr_stb, rd_stb, ice, syp, cwe, t3, t1, cs, em, as, uf;
  logic        s1v = 1'b0;
  logic        svf = 1'b1, mtk = 1'b0, mof = 1'b0, rsv = 1'b0;
  logic [15:0] rsum = 16'h0000;
  logic [15:0] wr_data, rd_data, gain_q, offset_q, v;
  logic [15:0] s1m = 16'h0000;
  logic [31:0] cw, last_w;
  logic [5:0]  ci;
  logic [2:0]  rate;
  int          fails = 0, cmp_count = 0, cyc = 0, syncs = 0, loads = 0, n;
  logic [15:0] sel_exp [3] = '{16'hCCCC, 16'hA000, 16'h0000};
  bus_host host (.clk_sys(clk_sys), .rd_data(rd_data), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb));
  conv_regs #(.PART_ID(2'h2), .DIE_ID(3'h5)) uut (.clk_sys(clk_sys), .rst(rst), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .conv_word(16'h5A5A), .sample_valid_flag(svf), .stage1_valid(s1v),
    .stage1_mag(s1m), .mod_tick(mtk), .mod_over_full(mof), .run_sum_valid(rsv), .run_sum(rsum),
    .rd_data(rd_data), .internal_clock_en(ice), .sync_pulse(syp), .coeff_we(cwe), .coeff_word(cw),
    .coeff_index(ci), .third_stage_active(t3), .first_stage_active(t1), .rate_reduce_field(rate),
    .chip_sleep(cs), .economy_mode(em), .amp_sleep(as), .user_filter(uf), .gain_q(gain_q), .offset_q(offset_q));
  // clock
  always #2 clk_sys = ~clk_sys;
  // event counters and hang limit
  always @(posedge clk_sys) begin
    cyc++;
    syncs += syp;
    if (cwe) begin
      loads++;
      last_w = cw;
    end
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // count enable pulses over eight cycles
  task automatic clk_count();
    n = 0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      n += ice;
    end
  endtask : clk_count
  // consecutive modulator samples above full reference
  task automatic over_ticks(input int k);
    mtk = 1'b1;
    mof = 1'b1;
    repeat (k) @(posedge clk_sys);
    #1;
    mtk = 1'b0;
    mof = 1'b0;
  endtask : over_ticks
  // one recomputed checksum from the filter
  task automatic sum_pulse(input logic [15:0] s);
    rsum = s;
    rsv = 1'b1;
    @(posedge clk_sys);
    #1;
    rsv = 1'b0;
  endtask : sum_pulse
  // select status, then read it
  task automatic status_rd();
    host.wr(conv_regs_pkg::ADDR_PRIMARY, 16'h081A);
    host.rd(v);
  endtask : status_rd
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    host.wr(conv_regs_pkg::ADDR_PRIMARY, 16'h081A);
    host.rd(v);
    chk(v, 16'hAC02);
    host.rd(v);
    chk(v, 16'h5A5A);
    for (int i = 0; i < 3; i++) begin
      host.wr(conv_regs_pkg::ADDR_PRIMARY, 16'h001A | (16'h4000 >> i));
      host.rd(v);
      chk(v, sel_exp[i]);
    end
    $display("test readback done");
    host.wr(conv_regs_pkg::ADDR_GAIN, 16'h8000);
    host.wr(conv_regs_pkg::ADDR_OFFSET, 16'h7FFF);
    host.wr(16'h0007, 16'h1234);
    chk(gain_q, 16'h8000);
    chk(offset_q, 16'h7FFF);
    $display("test correction done");
    host.wr(conv_regs_pkg::ADDR_SECONDARY, 16'h0027);
    clk_count();
    chk(n, 8);
    chk({em, as, cs}, 3'b110);
    host.wr(conv_regs_pkg::ADDR_PRIMARY, 16'h081A);
    host.rd(v);
    chk(v, 16'hAE02);
    host.wr(conv_regs_pkg::ADDR_SECONDARY, 16'h0003);
    clk_count();
    chk(n, 4);
    $display("test secondary done");
    host.wr(conv_regs_pkg::ADDR_PRIMARY, 16'h0200);
    chk(syncs, 1);
    chk({t3, t1, rate}, 5'h00);
    svf = 1'b0;
    host.wr(conv_regs_pkg::ADDR_PRIMARY, 16'h0800);
    host.rd(v);
    chk(v, 16'hA818);
    svf = 1'b1;
    $display("test bypass done");
    s1m = 16'hD000;
    s1v = 1'b1;
    @(posedge clk_sys);
    #1;
    s1v = 1'b0;
    host.wr(conv_regs_pkg::ADDR_PRIMARY, 16'h081A);
    host.rd(v);
    chk(v, 16'hAD02);
    s1m = 16'h1000;
    s1v = 1'b1;
    @(posedge clk_sys);
    #1;
    s1v = 1'b0;
    over_ticks(4);
    status_rd();
    chk(v, 16'hAC02);
    over_ticks(1);
    status_rd();
    chk(v, 16'hAD02);
    $display("test overrange done");
    host.wr(conv_regs_pkg::ADDR_PRIMARY, 16'h803A);
    repeat (6) begin
      host.wd(16'h0001);
      host.wd(16'h0203);
    end
    host.wd(16'h0024);
    chk(loads, 6);
    chk(last_w, 32'h00010203);
    chk(ci, 6'h05);
    chk(uf, 1'b1);
    sum_pulse(16'h0025);
    status_rd();
    chk(v & 16'h00E0, 16'h00A0);
    sum_pulse(16'h0024);
    status_rd();
    chk(v & 16'h00E0, 16'h00E0);
    $display("test download done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
